// *** emc_pkg.sv ***
// package for the programmable-memory host controller: command register map, pin group types, timing
package emc_pkg;
  // ********************************
  // sizes
  // ********************************
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int PULSE_MAX_DEF = 100;
  // ********************************
  // timing
  // ********************************
  localparam int CLK_MHZ = 125;
  localparam int PULSE_US = 100;
  localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int ACC_NS = 250;
  localparam int ACC_CYC = (ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int DF_NS = 40;
  localparam int DF_CYC = (DF_NS * CLK_MHZ + 999) / 1000;
  // ********************************
  // controller registers
  // ********************************
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h1;
  localparam logic [3:0] REG_CMD = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_SEL = 4'h5;
  localparam logic [3:0] REG_PCNT = 4'h6;
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_PROG = 3'h2;
  localparam logic [2:0] CMD_ID = 3'h3;
  localparam logic [2:0] CMD_DESEL = 3'h4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FAIL = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_VPPREQ = 3;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  // ********************************
  // pin group toward the memory
  // ********************************
  typedef struct packed {
    logic device_select_n;
    logic output_drive_n;
    logic program_strobe_n;
    logic vpp_prog_en;
    logic id_high_voltage_en;
    logic [ADDR_W-1:0] addr;
  } emc_pins_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b010,
    ST_RECOV = 3'b011,
    ST_VERIFY = 3'b100,
    ST_READ = 3'b101,
    ST_FLOAT = 3'b110
  } emc_state_e;
endpackage : emc_pkg

// *** emc_cnt.sv ***
// down counter used for pulse, access and float timing
`timescale 1ns/1ps
module emc_cnt #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [W-1:0] i_value,
  output logic o_zero
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  // reload wins over counting
  assign cnt_nxt = i_load ? i_value : (cnt_r != '0 ? cnt_r - W'(1) : cnt_r);
  assign o_zero = (cnt_r == '0);
  // ********************************
  // counter register
  // ********************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : emc_cnt

// *** emc_host.sv ***
// host controller driving an erasable programmable memory through its pins
// How it works
// (R1) program: select low pulse with strobe low, drive high, programming supply on
// (R2) only the chosen device is pulsed; others keep select high
// (R3) verify: select and drive low, strobe high, supply kept in window
// (R4) every programmed byte is read back and compared
// (R5) identifier mode: high voltage on trigger line while select and drive low
// (R6) byte select line low gives maker code, high gives part code
// (R7) all other address lines held low during identifier reads
// (R8) identifier bytes carry odd parity in top bit; host checks it
// (R9) data sampled only while select and drive are both low
// (R10) drive enable gates data separately from selection
// (R11) idle select held high (rail level) for deepest standby
// (R12) deselected device sits in logic standby
// (R13) no data expected from a device in standby
// (R14) drive line is a common read strobe; select decoded per device
// (R15) host drives data only while device drive line is high
// (R16) seventeen address lines, eight bidirectional data lines
// (R17) erased bits read one; programming only clears bits
// (R18) fixed pulses, verify after each, retry to maximum count
`timescale 1ns/1ps
module emc_host #(
  parameter int PULSE_CYC = emc_pkg::PULSE_CYC,
  parameter int PULSE_MAX = emc_pkg::PULSE_MAX_DEF,
  parameter int NDEV = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic [NDEV-1:0] o_device_select_n,
  output logic o_output_drive_n,
  output logic o_program_strobe_n,
  output logic o_vpp_prog_en,
  output logic o_id_high_voltage_en,
  output logic [emc_pkg::ADDR_W-1:0] o_addr,
  input wire logic [emc_pkg::DATA_W-1:0] i_data_lines,
  output logic [emc_pkg::DATA_W-1:0] o_data_lines,
  output logic o_data_lines_oe
);
  // counter must hold the longest load: the pulse or the access wait, whichever is larger
  localparam int CW = $clog2(((PULSE_CYC > emc_pkg::ACC_CYC) ? PULSE_CYC : emc_pkg::ACC_CYC) + 1) + 1;
  emc_pkg::emc_state_e st_r, st_nxt;
  emc_pkg::emc_pins_s pins_r, pins_nxt;
  logic [NDEV-1:0] sel_n_r;
  logic [emc_pkg::ADDR_W-1:0] addr_reg_r;
  logic [emc_pkg::DATA_W-1:0] wdata_r, rdata_r, din_s1_r, din_s2_r;
  logic [1:0] dev_r;
  logic [7:0] pcnt_r;
  logic busy_r, fail_r, done_r, oe_r, isid_r;
  logic [31:0] o_rdata_r;
  logic cnt_load, cnt_zero;
  logic [CW-1:0] cnt_val;
  logic cmd_wr;
  logic cmd_go;
  logic [2:0] cmd;
  logic verify_ok, parity_ok;

  emc_cnt #(.W(CW)) u_cnt (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(cnt_load),
    .i_value(cnt_val),
    .o_zero(cnt_zero)
  );

  // ********************************
  // command decode
  // ********************************
  assign cmd_wr = i_wr && (i_addr == emc_pkg::REG_CMD) && !busy_r;
  assign cmd = i_wdata[2:0];
  // only codes the sequencer acts on may raise busy; others would hang it
  assign cmd_go = cmd_wr && (cmd == emc_pkg::CMD_READ || cmd == emc_pkg::CMD_PROG || cmd == emc_pkg::CMD_ID);
  // cleared bits may never read back one again; any stored one where zero wanted fails
  assign verify_ok = (din_s2_r == wdata_r); // R4 R17
  assign parity_ok = ^din_s2_r; // R8

  // ********************************
  // sequencer, next state
  // ********************************
  always_comb begin
    st_nxt = st_r;
    pins_nxt = pins_r;
    cnt_load = 1'b0;
    cnt_val = '0;
    case (st_r)
      emc_pkg::ST_IDLE: begin
        pins_nxt.device_select_n = 1'b1; // R11 R12
        pins_nxt.output_drive_n = 1'b1;
        pins_nxt.program_strobe_n = 1'b1;
        if (cmd_wr && cmd == emc_pkg::CMD_PROG) begin
          // strobe low, drive high, supply on, select still high
          pins_nxt.program_strobe_n = 1'b0; // R1
          pins_nxt.vpp_prog_en = 1'b1;
          pins_nxt.addr = addr_reg_r;
          cnt_load = 1'b1;
          cnt_val = CW'(emc_pkg::DF_CYC);
          st_nxt = emc_pkg::ST_SETUP;
        end else if (cmd_wr && (cmd == emc_pkg::CMD_READ || cmd == emc_pkg::CMD_ID)) begin
          pins_nxt.device_select_n = 1'b0; // R9 R14
          pins_nxt.output_drive_n = 1'b0; // R10
          pins_nxt.id_high_voltage_en = (cmd == emc_pkg::CMD_ID); // R5
          // other address lines low in identifier mode
          pins_nxt.addr = (cmd == emc_pkg::CMD_ID) ? {{(emc_pkg::ADDR_W-1){1'b0}}, addr_reg_r[0]} : addr_reg_r; // R6 R7
          cnt_load = 1'b1;
          cnt_val = CW'(emc_pkg::ACC_CYC);
          st_nxt = emc_pkg::ST_READ;
        end else if (cmd_wr && cmd == emc_pkg::CMD_DESEL) begin
          pins_nxt.vpp_prog_en = 1'b0;
        end
      end
      emc_pkg::ST_SETUP: if (cnt_zero) begin
        pins_nxt.device_select_n = 1'b0; // R1
        cnt_load = 1'b1;
        cnt_val = CW'(PULSE_CYC);
        st_nxt = emc_pkg::ST_PULSE;
      end
      emc_pkg::ST_PULSE: if (cnt_zero) begin
        pins_nxt.device_select_n = 1'b1;
        cnt_load = 1'b1;
        cnt_val = CW'(emc_pkg::DF_CYC);
        st_nxt = emc_pkg::ST_RECOV;
      end
      emc_pkg::ST_RECOV: if (cnt_zero) begin
        // verify with supply still in its window
        pins_nxt.program_strobe_n = 1'b1; // R3
        pins_nxt.device_select_n = 1'b0;
        pins_nxt.output_drive_n = 1'b0;
        cnt_load = 1'b1;
        cnt_val = CW'(emc_pkg::ACC_CYC);
        st_nxt = emc_pkg::ST_VERIFY;
      end
      emc_pkg::ST_VERIFY, emc_pkg::ST_READ: if (cnt_zero) begin
        pins_nxt.device_select_n = 1'b1;
        pins_nxt.output_drive_n = 1'b1;
        pins_nxt.id_high_voltage_en = 1'b0;
        cnt_load = 1'b1;
        cnt_val = CW'(emc_pkg::DF_CYC);
        st_nxt = emc_pkg::ST_FLOAT;
        // retry pulse until verify or limit
        if (st_r == emc_pkg::ST_VERIFY && !verify_ok && pcnt_r < 8'(PULSE_MAX)) begin // R18
          pins_nxt.program_strobe_n = 1'b0;
          st_nxt = emc_pkg::ST_SETUP;
        end
      end
      emc_pkg::ST_FLOAT: if (cnt_zero) begin
        st_nxt = emc_pkg::ST_IDLE;
      end
      default: st_nxt = emc_pkg::ST_IDLE;
    endcase
  end

  // ********************************
  // state and pin registers
  // ********************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= emc_pkg::ST_IDLE;
      pins_r <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, '0};
    end else begin
      st_r <= st_nxt;
      pins_r <= pins_nxt;
    end
  end

  // ********************************
  // per-device select, only chosen one pulses
  // ********************************
  genvar g;
  generate
    for (g = 0; g < NDEV; g++) begin : g_sel
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          sel_n_r[g] <= 1'b1;
        end else begin
          sel_n_r[g] <= (dev_r == 2'(g)) ? pins_nxt.device_select_n : 1'b1; // R2 R14
        end
      end
    end
  endgenerate

  // ********************************
  // data pins: pin sync and host drive
  // ********************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      din_s1_r <= '0;
      din_s2_r <= '0;
      oe_r <= 1'b0;
    end else begin
      din_s1_r <= i_data_lines;
      din_s2_r <= din_s1_r;
      // drive only while memory outputs are disabled
      oe_r <= pins_nxt.output_drive_n && !pins_nxt.program_strobe_n; // R15 R16
    end
  end

  // ********************************
  // software registers and status
  // ********************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      addr_reg_r <= emc_pkg::ADDR_RST[emc_pkg::ADDR_W-1:0];
      wdata_r <= '0;
      rdata_r <= '0;
      dev_r <= '0;
      pcnt_r <= '0;
      busy_r <= 1'b0;
      fail_r <= 1'b0;
      done_r <= 1'b0;
      isid_r <= 1'b0;
      o_rdata_r <= '0;
    end else begin
      if (i_wr && i_addr == emc_pkg::REG_ADDR) addr_reg_r <= i_wdata[emc_pkg::ADDR_W-1:0];
      if (i_wr && i_addr == emc_pkg::REG_WDATA) wdata_r <= i_wdata[emc_pkg::DATA_W-1:0];
      if (i_wr && i_addr == emc_pkg::REG_SEL) dev_r <= i_wdata[1:0];
      if (cmd_go) begin
        busy_r <= 1'b1;
        done_r <= 1'b0;
        fail_r <= 1'b0;
        pcnt_r <= '0;
        isid_r <= (cmd == emc_pkg::CMD_ID);
      end
      if (st_r == emc_pkg::ST_PULSE && cnt_zero) pcnt_r <= pcnt_r + 8'h01;
      // sample while select and drive are both low
      if ((st_r == emc_pkg::ST_READ || st_r == emc_pkg::ST_VERIFY) && cnt_zero) begin // R9 R13
        rdata_r <= din_s2_r;
        if (st_r == emc_pkg::ST_READ && isid_r && !parity_ok) fail_r <= 1'b1; // R8
        if (st_r == emc_pkg::ST_VERIFY && !verify_ok && pcnt_r >= 8'(PULSE_MAX)) fail_r <= 1'b1; // R18
      end
      if (st_r == emc_pkg::ST_FLOAT && cnt_zero) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
      // read data stand one cycle after the strobe, zero otherwise
      if (!i_rd) begin
        o_rdata_r <= 32'h0000_0000;
      end else begin
        case (i_addr)
          emc_pkg::REG_ADDR: o_rdata_r <= 32'(addr_reg_r);
          emc_pkg::REG_WDATA: o_rdata_r <= 32'(wdata_r);
          emc_pkg::REG_STAT: o_rdata_r <= 32'({pins_r.vpp_prog_en, done_r, fail_r, busy_r});
          emc_pkg::REG_RDATA: o_rdata_r <= 32'(rdata_r);
          emc_pkg::REG_SEL: o_rdata_r <= 32'(dev_r);
          emc_pkg::REG_PCNT: o_rdata_r <= 32'(pcnt_r);
          default: o_rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ********************************
  // outputs, all from flops
  // ********************************
  assign o_rdata = o_rdata_r;
  assign o_device_select_n = sel_n_r;
  assign o_output_drive_n = pins_r.output_drive_n;
  assign o_program_strobe_n = pins_r.program_strobe_n;
  assign o_vpp_prog_en = pins_r.vpp_prog_en;
  assign o_id_high_voltage_en = pins_r.id_high_voltage_en;
  assign o_addr = pins_r.addr;
  assign o_data_lines = wdata_r;
  assign o_data_lines_oe = oe_r;
endmodule : emc_host

// *** emc_mem_model.sv ***
// behavioural model of the programmable memories on the host pins
`timescale 1ns/1ps
module emc_mem_model #(
  parameter int NDEV = 4,
  parameter logic [7:0] MAKER_ID = 8'h2A, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h8C, // arbitrary value
  parameter int BAD_DEV = 3
) (
  input wire logic i_clk,
  input wire logic [NDEV-1:0] i_sel_n,
  input wire logic i_oe_n,
  input wire logic i_pgm_n,
  input wire logic i_vpp,
  input wire logic i_idhv,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_din,
  input wire logic i_din_oe,
  output logic [7:0] o_dout
);
  logic [7:0] mem [int];
  logic [NDEV-1:0] prev_n = '1;
  logic [7:0] last = 8'h00;
  logic prog_ok = 1'b0;
  logic [7:0] prog_din = 8'h00;
  // ****
  // storage
  // ****
  function automatic logic [7:0] rdb(input int d);
    int k;
    k = d * 131072 + int'(i_addr);
    return mem.exists(k) ? mem[k] : 8'hFF;
  endfunction : rdb
  // program at the end of a select pulse, judged on the levels held during the pulse;
  // sampling on the clock avoids racing pins that all change at one edge
  always @(posedge i_clk) begin
    for (int d = 0; d < NDEV; d++) begin
      if (!prev_n[d] && i_sel_n[d] && prog_ok) begin
        mem[d * 131072 + int'(i_addr)] = rdb(d) & prog_din;
      end
    end
    prev_n = i_sel_n;
    prog_ok = !i_pgm_n && i_oe_n && i_vpp && i_din_oe;
    prog_din = i_din;
  end
  // shared data lines; released lines toggle so stale data never passes
  always @* begin
    o_dout = i_din_oe ? i_din : ~last;
    for (int d = 0; d < NDEV; d++) begin
      if (!i_sel_n[d] && !i_oe_n) begin
        o_dout = i_idhv ? ((i_addr[0] ? PART_ID : MAKER_ID) ^ (d == BAD_DEV ? 8'h80 : 8'h00)) : rdb(d);
      end
    end
  end
  // remember the last level for the toggle pattern
  always @(posedge i_clk) last <= o_dout;
endmodule : emc_mem_model

// *** emc_host_props.sv ***
// concurrent checks on the host controller ports
`timescale 1ns/1ps
module emc_host_props #(
  parameter int NDEV = 4,
  parameter int PULSE_CYC = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [NDEV-1:0] o_device_select_n,
  input wire logic o_output_drive_n,
  input wire logic o_program_strobe_n,
  input wire logic o_vpp_prog_en,
  input wire logic o_id_high_voltage_en,
  input wire logic [emc_pkg::ADDR_W-1:0] o_addr,
  input wire logic o_data_lines_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire sel_any = !(&o_device_select_n);
  wire pulse = sel_any && !o_program_strobe_n;
  logic [15:0] plen_r;
  // pulse length counter; a stuck pulse would overstress the cell
  always_ff @(posedge i_clk) plen_r <= (i_sys_rst || !pulse) ? 16'h0 : plen_r + 16'h1;
  // ****
  // pin relations
  // ****
  prog_gate_a: assert property (pulse |-> o_vpp_prog_en && o_output_drive_n)
    else $error("program pulse without supply or with drive");
  one_dev_a: assert property ($onehot0(~o_device_select_n))
    else $error("more than one device selected");
  verify_mode_a: assert property (sel_any && !o_output_drive_n && o_vpp_prog_en |-> o_program_strobe_n)
    else $error("verify with strobe low");
  id_addr_a: assert property (o_id_high_voltage_en |-> o_addr[16:1] == 16'h0)
    else $error("upper address not low in identifier mode");
  no_clash_a: assert property (o_data_lines_oe |-> o_output_drive_n)
    else $error("host drives data while memory drives");
  idle_rel_a: assert property ($fell(i_sys_rst) |-> &o_device_select_n && o_output_drive_n
    && !o_data_lines_oe && !o_vpp_prog_en)
    else $error("pins not idle after reset");
  addr_hold_a: assert property (sel_any && !o_output_drive_n && $past(sel_any) && !$past(o_output_drive_n)
    |-> $stable(o_addr))
    else $error("address moved during read");
  pulse_len_a: assert property (plen_r <= 16'(PULSE_CYC + 2))
    else $error("program pulse too long");
  rdata_gate_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : emc_host_props
bind emc_host emc_host_props #(.NDEV(NDEV), .PULSE_CYC(PULSE_CYC)) u_props (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_rd(i_rd), .o_rdata(o_rdata), .o_device_select_n(o_device_select_n),
  .o_output_drive_n(o_output_drive_n), .o_program_strobe_n(o_program_strobe_n),
  .o_vpp_prog_en(o_vpp_prog_en), .o_id_high_voltage_en(o_id_high_voltage_en),
  .o_addr(o_addr), .o_data_lines_oe(o_data_lines_oe));

// *** emc_host_test.sv ***
// self-checking bench for the programmable-memory host controller
`timescale 1ns/1ps
module emc_host_test;
  localparam int NDEV = 4;
  localparam int PMAX = 3;
  localparam logic [7:0] MAKER = 8'h2A; // arbitrary value
  localparam logic [7:0] PART = 8'h8C; // arbitrary value
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [31:0] o_rdata, v;
  logic [NDEV-1:0] sel_n;
  logic oe_n, pgm_n, vpp, idhv, doe;
  logic [16:0] maddr;
  logic [7:0] to_mem, from_mem;
  int error_cnt = 0;
  int compares = 0;
  emc_host #(.PULSE_CYC(4), .PULSE_MAX(PMAX), .NDEV(NDEV)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_device_select_n(sel_n), .o_output_drive_n(oe_n), .o_program_strobe_n(pgm_n), .o_vpp_prog_en(vpp),
    .o_id_high_voltage_en(idhv), .o_addr(maddr), .i_data_lines(from_mem), .o_data_lines(to_mem),
    .o_data_lines_oe(doe));
  emc_mem_model #(.NDEV(NDEV), .MAKER_ID(MAKER), .PART_ID(PART), .BAD_DEV(3)) u_mem (.i_clk(i_clk),
    .i_sel_n(sel_n), .i_oe_n(oe_n), .i_pgm_n(pgm_n), .i_vpp(vpp), .i_idhv(idhv), .i_addr(maddr),
    .i_din(to_mem), .i_din_oe(doe), .o_dout(from_mem));
  // 125 MHz clock
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  // ****
  // bus and check helpers
  // ****
  task automatic complete_run;
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rdchk(input string n, input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
    if (n != "") chk(n, e, v);
  endtask : rdchk
  // command then bounded poll of busy
  task automatic op(input int d, input logic [31:0] a, input logic [31:0] wd, input logic [2:0] c);
    int n;
    wr(emc_pkg::REG_SEL, d);
    wr(emc_pkg::REG_ADDR, a);
    wr(emc_pkg::REG_WDATA, wd);
    wr(emc_pkg::REG_CMD, {29'h0, c});
    v = 32'h1;
    for (n = 0; n < 4000 && v[emc_pkg::STAT_BUSY] !== 1'b0; n++) rdchk("", emc_pkg::REG_STAT, 0);
    if (n == 4000) begin
      chk("busy", 32'h0, v);
      complete_run();
    end
  endtask : op
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    chk("idle_pins", {23'h0, 4'hF, 5'h18}, {23'h0, sel_n, oe_n, pgm_n, vpp, idhv, doe});
    rdchk("unmapped", 4'hF, 32'h0);
    wr(emc_pkg::REG_CMD, 32'h0000_0000);
    rdchk("bad_cmd", emc_pkg::REG_STAT, 32'h0);
  endtask : t_reset
  task automatic t_prog;
    op(1, 32'h12345, 0, emc_pkg::CMD_READ);
    rdchk("erased", emc_pkg::REG_RDATA, 32'hFF);
    op(1, 32'h12345, 32'h5A, emc_pkg::CMD_PROG);
    rdchk("prog_stat", emc_pkg::REG_STAT, 32'hC);
    rdchk("pulses", emc_pkg::REG_PCNT, 32'h1);
    op(1, 32'h12345, 0, emc_pkg::CMD_READ);
    rdchk("prog_data", emc_pkg::REG_RDATA, 32'h5A);
    op(2, 32'h12345, 0, emc_pkg::CMD_READ);
    rdchk("other_dev", emc_pkg::REG_RDATA, 32'hFF);
  endtask : t_prog
  task automatic t_fail;
    op(1, 32'h12345, 32'hA5, emc_pkg::CMD_PROG);
    rdchk("fail_stat", emc_pkg::REG_STAT, 32'hE);
    rdchk("fail_pulses", emc_pkg::REG_PCNT, PMAX);
    op(1, 32'h12345, 0, emc_pkg::CMD_READ);
    rdchk("fail_data", emc_pkg::REG_RDATA, 32'h0);
  endtask : t_fail
  task automatic t_id;
    logic [7:0] e;
    for (int d = 0; d < 4; d += 3) begin
      for (int a = 0; a < 2; a++) begin
        e = (a == 1 ? PART : MAKER) ^ (d == 3 ? 8'h80 : 8'h00);
        op(d, 32'h1FFF0 | a, 0, emc_pkg::CMD_ID);
        rdchk("id_byte", emc_pkg::REG_RDATA, {24'h0, e});
        rdchk("id_stat", emc_pkg::REG_STAT, (d == 3) ? 32'hE : 32'hC);
      end
    end
    op(0, 0, 0, emc_pkg::CMD_DESEL);
    chk("vpp_off", 32'h0, {31'h0, vpp});
  endtask : t_id
  // main sequence
  initial begin
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_prog();
    t_fail();
    t_id();
    complete_run();
  end
endmodule : emc_host_test
